/* src/opd_pkg.sv */
package opd_pkg;

	// ****************************************************************
	// Widths and field positions.
	// ****************************************************************
	localparam int BYTE_W   = 8;
	localparam int NIB_W    = 4;
	localparam int NIB_HI   = 4;
	localparam int ADDR_W   = 12;
	localparam int PC_W     = 16;
	localparam int BIT_W    = 3;
	localparam int POL_POS  = 7;
	localparam int BITN_MSB = 6;
	localparam int BITN_LSB = 4;
	localparam int PAIR_LSB = 0;

	// ****************************************************************
	// Codes and reset values.
	// ****************************************************************
	localparam logic [BYTE_W-1:0] OPC_ADD_REG = 8'h04;
	localparam logic [NIB_W-1:0]  ESC_NIB    = 4'hE;
	localparam logic [NIB_W-1:0]  SHORT_PAGE = 4'h0;
	localparam logic [BYTE_W-1:0] BYTE_RST   = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_RST   = 12'h000;
	localparam logic [PC_W-1:0]   PC_RST     = 16'h0000;
	localparam logic [BIT_W-1:0]  BITN_RST   = 3'h0;

	// ****************************************************************
	// Operand formats and write-back states.
	// ****************************************************************
	typedef enum logic [3:0] {
		FMT_R_R,
		FMT_R_IMM,
		FMT_IND_R,
		FMT_PAIR,
		FMT_IRR,
		FMT_EXT_EXT,
		FMT_EXT_IMM,
		FMT_DIRECT,
		FMT_REL,
		FMT_X,
		FMT_VEC,
		FMT_BIT
	} opd_fmt_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_READ,
		ST_WRITE
	} opd_state_t;

	// ****************************************************************
	// Shared decoding.
	// ****************************************************************
	function automatic logic [PC_W-1:0] opd_sext(
		input logic [BYTE_W-1:0] v
	);
		opd_sext = {{(PC_W-BYTE_W){v[BYTE_W-1]}}, v};
	endfunction : opd_sext

	function automatic logic opd_is_pair(input opd_fmt_t f);
		opd_is_pair = (f == FMT_PAIR) || (f == FMT_IRR);
	endfunction : opd_is_pair

endpackage : opd_pkg

/* src/opd_reg_resolve.sv */
`timescale 1ns/1ps
module opd_reg_resolve (
	input  wire logic [opd_pkg::BYTE_W-1:0] reg_byte,
	input  wire logic [opd_pkg::ADDR_W-1:0] working_base,
	input  wire logic                       pair_req,
	output logic      [opd_pkg::ADDR_W-1:0] resolved_addr,
	output logic                            is_working,
	output logic                            pair_odd
);
	import opd_pkg::*;

	// ****************************************************************
	// Escaped working register and pair alignment.
	// ****************************************************************
	assign is_working = reg_byte[BYTE_W-1:NIB_HI] == ESC_NIB;
	assign resolved_addr = is_working ?
		{working_base[ADDR_W-1:NIB_W], reg_byte[NIB_W-1:0]} :
		{SHORT_PAGE, reg_byte};
	assign pair_odd = pair_req & reg_byte[PAIR_LSB];

endmodule : opd_reg_resolve

/* src/opd_decoder.sv */
`timescale 1ns/1ps
// Operation
// - Operand bytes come source first, unless dst_first selects reverse; opcode 04 in register-register format ignores dst_first.
// - Opcode 04 takes source, then destination, and adds into destination.
// - A register byte reaches 0 to 255 or, escaped, 16 working registers.
// - A bit number is a 3-bit field choosing bit 0 to 7.
// - A direct address is a full 16-bit program address.
// - An extended register operand is a 12-bit register file address.
// - An immediate is one 8-bit byte taken from the instruction stream.
// - Direct and indirect register operands are 8-bit, over 256 locations.
// - Register pairs may only start at even addresses.
// - A relative offset is a signed byte added to the next instruction.
// - An indexed address is the base plus a signed 8-bit index.
// - A vector operand is an 8-bit value over the whole byte range.
// - A polarity operand is one bit choosing clear or set.
module opd_decoder (
	input  wire logic                       clk,
	input  wire logic                       nrst,
	input  wire logic                       ins_valid,
	output logic                            ins_ready,
	input  wire logic [opd_pkg::BYTE_W-1:0] opcode,
	input  wire logic [opd_pkg::BYTE_W-1:0] opd_byte1,
	input  wire logic [opd_pkg::BYTE_W-1:0] opd_byte2,
	input  wire logic [opd_pkg::BYTE_W-1:0] opd_byte3,
	input  wire opd_pkg::opd_fmt_t          opd_fmt,
	input  wire logic                       dst_first,
	input  wire logic [opd_pkg::PC_W-1:0]   next_pc,
	input  wire logic [opd_pkg::ADDR_W-1:0] working_base,
	input  wire logic [opd_pkg::BYTE_W-1:0] src_rdata,
	input  wire logic [opd_pkg::BYTE_W-1:0] dst_rdata,
	output logic                            dec_valid,
	output logic      [opd_pkg::ADDR_W-1:0] src_addr,
	output logic      [opd_pkg::ADDR_W-1:0] dst_addr,
	output logic                            src_is_working,
	output logic                            dst_is_working,
	output logic                            src_indirect,
	output logic                            pair_error,
	output logic      [opd_pkg::BYTE_W-1:0] immediate_operand,
	output logic      [opd_pkg::PC_W-1:0]   direct_address_operand,
	output logic      [opd_pkg::PC_W-1:0]   branch_target,
	output logic      [opd_pkg::BIT_W-1:0]  bit_num,
	output logic                            polarity,
	output logic      [opd_pkg::BYTE_W-1:0] vector_addr,
	output logic                            sum_wr,
	output logic      [opd_pkg::ADDR_W-1:0] sum_addr,
	output logic      [opd_pkg::BYTE_W-1:0] sum_data
);
	import opd_pkg::*;

	// ****************************************************************
	// Declarations.
	// ****************************************************************
	logic                take;
	logic                add_reg;
	logic                ord_dst_first;
	logic                pair_req;
	logic [BYTE_W-1:0]   src_byte;
	logic [BYTE_W-1:0]   dst_byte;
	logic [BYTE_W-1:0]   dst_sel;
	logic [ADDR_W-1:0]   src_res;
	logic [ADDR_W-1:0]   dst_res;
	logic                src_work;
	logic                dst_work;
	logic                src_odd;
	logic                dst_odd;
	logic [PC_W-1:0]     rel_ext;
	logic [PC_W-1:0]     idx_ext;
	logic [ADDR_W-1:0]   next_src_addr;
	logic [ADDR_W-1:0]   next_dst_addr;
	logic                next_src_ind;
	logic                next_err;
	logic [BYTE_W-1:0]   next_imm;
	logic [PC_W-1:0]     next_da;
	logic [PC_W-1:0]     next_target;
	logic [BIT_W-1:0]    next_bitn;
	logic                next_pol;
	logic [BYTE_W-1:0]   next_vec;
	opd_state_t          state;
	opd_state_t          next_state;

	// ****************************************************************
	// Acceptance and operand order.
	// ****************************************************************
	assign ins_ready = state == ST_IDLE;
	assign take = ins_valid & ins_ready;
	assign add_reg = (opcode == OPC_ADD_REG) && (opd_fmt == FMT_R_R);
	assign ord_dst_first = dst_first & ~add_reg;
	assign src_byte = ord_dst_first ? opd_byte2 : opd_byte1;
	assign dst_byte = ord_dst_first ? opd_byte1 : opd_byte2;
	assign pair_req = opd_is_pair(opd_fmt);
	assign rel_ext = opd_sext(opd_byte1);
	assign idx_ext = opd_sext(opd_byte2);

	always_comb begin
		case (opd_fmt)
			FMT_R_IMM, FMT_X: begin
				dst_sel = opd_byte1;
			end
			FMT_BIT: begin
				dst_sel = opd_byte2;
			end
			default: begin
				dst_sel = dst_byte;
			end
		endcase
	end

	// ****************************************************************
	// Register field resolution.
	// ****************************************************************
	opd_reg_resolve u_src (
		.reg_byte      (src_byte),
		.working_base  (working_base),
		.pair_req      (pair_req),
		.resolved_addr (src_res),
		.is_working    (src_work),
		.pair_odd      (src_odd)
	);

	opd_reg_resolve u_dst (
		.reg_byte      (dst_sel),
		.working_base  (working_base),
		.pair_req      (pair_req),
		.resolved_addr (dst_res),
		.is_working    (dst_work),
		.pair_odd      (dst_odd)
	);

	// ****************************************************************
	// Operand decode by format.
	// ****************************************************************
	always_comb begin
		next_src_addr = src_res;
		next_dst_addr = dst_res;
		next_src_ind  = 1'b0;
		next_err      = src_odd | dst_odd;
		next_imm      = BYTE_RST;
		next_da       = PC_RST;
		next_target   = PC_RST;
		next_bitn     = BITN_RST;
		next_pol      = 1'b0;
		next_vec      = BYTE_RST;
		case (opd_fmt)
			FMT_R_IMM: begin
				next_imm = opd_byte2;
			end
			FMT_IND_R, FMT_IRR: begin
				next_src_ind = 1'b1;
			end
			FMT_EXT_EXT: begin
				next_src_addr = {opd_byte1, opd_byte2[BYTE_W-1:NIB_HI]};
				next_dst_addr = {opd_byte2[NIB_W-1:0], opd_byte3};
			end
			FMT_EXT_IMM: begin
				next_imm      = opd_byte1;
				next_dst_addr = {opd_byte2[NIB_W-1:0], opd_byte3};
			end
			FMT_DIRECT: begin
				next_da = {opd_byte1, opd_byte2};
			end
			FMT_REL: begin
				next_target = PC_W'(next_pc + rel_ext);
			end
			FMT_X: begin
				next_dst_addr = ADDR_W'(dst_res + idx_ext[ADDR_W-1:0]);
			end
			FMT_VEC: begin
				next_vec = opd_byte1;
			end
			FMT_BIT: begin
				next_bitn = opd_byte1[BITN_MSB:BITN_LSB];
				next_pol  = opd_byte1[POL_POS];
			end
			default: begin
				next_src_ind = 1'b0;
			end
		endcase
	end

	// ****************************************************************
	// Decoded operand registers.
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (!nrst) begin
			dec_valid <= 1'b0;
		end else begin
			dec_valid <= take;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			src_addr               <= ADDR_RST;
			dst_addr               <= ADDR_RST;
			src_is_working         <= 1'b0;
			dst_is_working         <= 1'b0;
			src_indirect           <= 1'b0;
			pair_error             <= 1'b0;
			immediate_operand      <= BYTE_RST;
			direct_address_operand <= PC_RST;
			branch_target          <= PC_RST;
			bit_num                <= BITN_RST;
			polarity               <= 1'b0;
			vector_addr            <= BYTE_RST;
		end else if (take) begin
			src_addr               <= next_src_addr;
			dst_addr               <= next_dst_addr;
			src_is_working         <= src_work;
			dst_is_working         <= dst_work;
			src_indirect           <= next_src_ind;
			pair_error             <= next_err;
			immediate_operand      <= next_imm;
			direct_address_operand <= next_da;
			branch_target          <= next_target;
			bit_num                <= next_bitn;
			polarity               <= next_pol;
			vector_addr            <= next_vec;
		end
	end

	// ****************************************************************
	// Register addition write-back.
	// ****************************************************************
	always_comb begin
		case (state)
			ST_IDLE: begin
				next_state = (take && add_reg) ? ST_READ : ST_IDLE;
			end
			ST_READ: begin
				next_state = ST_WRITE;
			end
			ST_WRITE: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			sum_wr   <= 1'b0;
			sum_addr <= ADDR_RST;
			sum_data <= BYTE_RST;
		end else begin
			sum_wr <= state == ST_READ;
			if (state == ST_READ) begin
				sum_data <= BYTE_W'(src_rdata + dst_rdata);
				sum_addr <= dst_addr;
			end
		end
	end

	// ****************************************************************
	// Checks.
	// ****************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	a_order_reverse: assert property (
		take && opd_fmt == FMT_R_R && !add_reg && dst_first &&
		opd_byte1[BYTE_W-1:NIB_HI] != ESC_NIB
		|=> dst_addr == {SHORT_PAGE, $past(opd_byte1)})
		else $error("reversed operand order not honoured");

	a_add_writeback: assert property (
		take && add_reg
		|-> ##1 (dst_addr[BYTE_W-1:0] == $past(opd_byte2) ||
			dst_is_working)
		##1 (sum_wr && sum_addr == $past(dst_addr) &&
			sum_data == BYTE_W'($past(src_rdata) + $past(dst_rdata))))
		else $error("register addition written back wrongly");

	a_escape_reg: assert property (
		take && opd_fmt == FMT_R_R &&
		src_byte[BYTE_W-1:NIB_HI] == ESC_NIB
		|=> src_is_working &&
		src_addr[NIB_W-1:0] == $past(src_byte[NIB_W-1:0]))
		else $error("escaped register not decoded");

	a_bit_fields: assert property (
		take && opd_fmt == FMT_BIT
		|=> bit_num == $past(opd_byte1[BITN_MSB:BITN_LSB]) &&
		polarity == $past(opd_byte1[POL_POS]))
		else $error("bit number or polarity wrong");

	a_direct_addr: assert property (
		take && opd_fmt == FMT_DIRECT
		|=> direct_address_operand ==
		{$past(opd_byte1), $past(opd_byte2)})
		else $error("direct address wrong");

	a_ext_reg: assert property (
		take && opd_fmt == FMT_EXT_EXT
		|=> src_addr == {$past(opd_byte1),
		$past(opd_byte2[BYTE_W-1:NIB_HI])})
		else $error("extended source address wrong");

	a_imm_byte: assert property (
		take && opd_fmt == FMT_R_IMM
		|=> immediate_operand == $past(opd_byte2))
		else $error("immediate byte wrong");

	a_pair_odd: assert property (
		take && pair_req && src_byte[PAIR_LSB]
		|=> pair_error)
		else $error("odd pair address not flagged");

	a_rel_target: assert property (
		take && opd_fmt == FMT_REL
		|=> branch_target == $past(next_pc) + $past(rel_ext))
		else $error("relative target wrong");

	a_index_addr: assert property (
		take && opd_fmt == FMT_X
		|=> dst_addr == $past(dst_res) + $past(idx_ext[ADDR_W-1:0]))
		else $error("indexed address wrong");

	a_busy_gap: assert property (
		take && add_reg |=> !ins_ready [*2] ##1 ins_ready)
		else $error("ready not held low during write-back");

	c_add_done: cover property (take && add_reg ##2 sum_wr);
	c_escaped: cover property (take && src_work);
	c_pair_err: cover property (dec_valid && pair_error);
	c_reversed: cover property (take && ord_dst_first);

endmodule : opd_decoder

/* dv/opd_decoder_tb.sv */
`timescale 1ns/1ps
module opd_decoder_tb;
	import opd_pkg::*;

	// ************************************************************
	// Stimulus and observed signals.
	// ************************************************************
	logic              clk;
	logic              nrst;
	logic              ins_valid;
	logic              ins_ready;
	logic [7:0]        opcode;
	logic [7:0]        opd_byte1;
	logic [7:0]        opd_byte2;
	logic [7:0]        opd_byte3;
	opd_fmt_t          opd_fmt;
	logic              dst_first;
	logic [15:0]       next_pc;
	logic [11:0]       working_base;
	logic [7:0]        src_rdata;
	logic [7:0]        dst_rdata;
	logic              dec_valid;
	logic [11:0]       src_addr;
	logic [11:0]       dst_addr;
	logic              src_is_working;
	logic              dst_is_working;
	logic              src_indirect;
	logic              pair_error;
	logic [7:0]        immediate_operand;
	logic [15:0]       direct_address_operand;
	logic [15:0]       branch_target;
	logic [2:0]        bit_num;
	logic              polarity;
	logic [7:0]        vector_addr;
	logic              sum_wr;
	logic [11:0]       sum_addr;
	logic [7:0]        sum_data;
	int                n_fail;
	int                check_count;

	opd_decoder u_dut (.clk(clk), .nrst(nrst), .ins_valid(ins_valid),
		.ins_ready(ins_ready), .opcode(opcode), .opd_byte1(opd_byte1),
		.opd_byte2(opd_byte2), .opd_byte3(opd_byte3), .opd_fmt(opd_fmt),
		.dst_first(dst_first), .next_pc(next_pc),
		.working_base(working_base), .src_rdata(src_rdata),
		.dst_rdata(dst_rdata), .dec_valid(dec_valid), .src_addr(src_addr),
		.dst_addr(dst_addr), .src_is_working(src_is_working),
		.dst_is_working(dst_is_working), .src_indirect(src_indirect),
		.pair_error(pair_error), .immediate_operand(immediate_operand),
		.direct_address_operand(direct_address_operand),
		.branch_target(branch_target), .bit_num(bit_num),
		.polarity(polarity), .vector_addr(vector_addr), .sum_wr(sum_wr),
		.sum_addr(sum_addr), .sum_data(sum_data));

	// ************************************************************
	// Shared tasks.
	// ************************************************************
	task automatic check(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic conclude();
		if (n_fail == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude

	task automatic issue(input logic [7:0] op, input opd_fmt_t f,
		input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3,
		input logic df);
		@(posedge clk);
		#1;
		opcode = op;
		opd_fmt = f;
		opd_byte1 = b1;
		opd_byte2 = b2;
		opd_byte3 = b3;
		dst_first = df;
		ins_valid = 1'b1;
		check("ins_ready", 16'(ins_ready), 16'h0001);
		@(posedge clk);
		#1;
		ins_valid = 1'b0;
		check("dec_valid", 16'(dec_valid), 16'h0001);
	endtask : issue

	// ************************************************************
	// Scenarios.
	// ************************************************************
	task automatic t_reset();
		check("rst_ready", 16'(ins_ready), 16'h0001);
		check("rst_valid", 16'(dec_valid), 16'h0000);
		check("rst_sum_wr", 16'(sum_wr), 16'h0000);
	endtask : t_reset

	task automatic t_add();
		issue(OPC_ADD_REG, FMT_R_R, 8'hE8, 8'h43, 8'h00, 1'b1);
		check("add_src", 16'(src_addr), 16'h0AB8);
		check("add_src_w", 16'(src_is_working), 16'h0001);
		check("add_dst", 16'(dst_addr), 16'h0043);
		check("add_busy", 16'(ins_ready), 16'h0000);
		src_rdata = 8'hF0;
		dst_rdata = 8'h25;
		@(posedge clk);
		#1;
		check("sum_wr", 16'(sum_wr), 16'h0001);
		check("sum_addr", 16'(sum_addr), 16'h0043);
		check("sum_data", 16'(sum_data), 16'h0015);
		check("add_busy2", 16'(ins_ready), 16'h0000);
		@(posedge clk);
		#1;
		check("sum_wr_end", 16'(sum_wr), 16'h0000);
		check("add_free", 16'(ins_ready), 16'h0001);
	endtask : t_add

	task automatic t_order();
		issue(8'h14, FMT_R_R, 8'h12, 8'hE5, 8'h00, 1'b1);
		check("ord_src", 16'(src_addr), 16'h0AB5);
		check("ord_dst", 16'(dst_addr), 16'h0012);
		check("ord_dst_w", 16'(dst_is_working), 16'h0000);
		issue(8'h14, FMT_R_R, 8'h12, 8'hE5, 8'h00, 1'b0);
		check("ord2_src", 16'(src_addr), 16'h0012);
		check("ord2_dst_w", 16'(dst_is_working), 16'h0001);
	endtask : t_order

	task automatic t_fields();
		issue(8'h10, FMT_DIRECT, 8'hFF, 8'hFE, 8'h00, 1'b0);
		check("direct", direct_address_operand, 16'hFFFE);
		issue(8'h18, FMT_EXT_EXT, 8'hAB, 8'hCD, 8'hEF, 1'b0);
		check("ext_src", 16'(src_addr), 16'h0ABC);
		check("ext_dst", 16'(dst_addr), 16'h0DEF);
		issue(8'h19, FMT_EXT_IMM, 8'h5A, 8'h03, 8'h21, 1'b0);
		check("ext_imm", 16'(immediate_operand), 16'h005A);
		check("ext_imm_dst", 16'(dst_addr), 16'h0321);
		issue(8'h06, FMT_R_IMM, 8'hFF, 8'hFF, 8'h00, 1'b0);
		check("imm_dst", 16'(dst_addr), 16'h00FF);
		check("imm_val", 16'(immediate_operand), 16'h00FF);
		issue(8'h07, FMT_IND_R, 8'h80, 8'h00, 8'h00, 1'b0);
		check("ind_flag", 16'(src_indirect), 16'h0001);
		check("ind_src", 16'(src_addr), 16'h0080);
		issue(8'h30, FMT_VEC, 8'hFF, 8'h00, 8'h00, 1'b0);
		check("vector", 16'(vector_addr), 16'h00FF);
		check("vec_ind", 16'(src_indirect), 16'h0000);
		@(posedge clk);
		#1;
		check("valid_drop", 16'(dec_valid), 16'h0000);
	endtask : t_fields

	task automatic t_pairs();
		issue(8'h24, FMT_PAIR, 8'hFE, 8'hEE, 8'h00, 1'b0);
		check("pair_ok", 16'(pair_error), 16'h0000);
		issue(8'h24, FMT_PAIR, 8'hE3, 8'h10, 8'h00, 1'b0);
		check("pair_w_odd", 16'(pair_error), 16'h0001);
		issue(8'h25, FMT_IRR, 8'h10, 8'hFF, 8'h00, 1'b0);
		check("pair_odd", 16'(pair_error), 16'h0001);
		check("pair_ind", 16'(src_indirect), 16'h0001);
	endtask : t_pairs

	task automatic t_offsets();
		next_pc = 16'h1000;
		issue(8'h8B, FMT_REL, 8'h80, 8'h00, 8'h00, 1'b0);
		check("rel_neg", branch_target, 16'h0F80);
		issue(8'h8B, FMT_REL, 8'h7F, 8'h00, 8'h00, 1'b0);
		check("rel_pos", branch_target, 16'h107F);
		issue(8'h87, FMT_X, 8'h10, 8'hF0, 8'h00, 1'b0);
		check("idx_neg", 16'(dst_addr), 16'h0000);
		issue(8'h87, FMT_X, 8'h80, 8'h7F, 8'h00, 1'b0);
		check("idx_pos", 16'(dst_addr), 16'h00FF);
	endtask : t_offsets

	task automatic t_bits();
		issue(8'hE2, FMT_BIT, 8'hF0, 8'h44, 8'h00, 1'b0);
		check("bit_hi", 16'(bit_num), 16'h0007);
		check("pol_set", 16'(polarity), 16'h0001);
		check("bit_dst", 16'(dst_addr), 16'h0044);
		issue(8'hE2, FMT_BIT, 8'h0F, 8'h44, 8'h00, 1'b0);
		check("bit_lo", 16'(bit_num), 16'h0000);
		check("pol_clr", 16'(polarity), 16'h0000);
	endtask : t_bits

	// ************************************************************
	// Clock, reset, sequence and watchdog.
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		n_fail = 0;
		check_count = 0;
		nrst = 1'b0;
		ins_valid = 1'b0;
		opcode = 8'h00;
		opd_byte1 = 8'h00;
		opd_byte2 = 8'h00;
		opd_byte3 = 8'h00;
		opd_fmt = FMT_R_R;
		dst_first = 1'b0;
		next_pc = 16'h0000;
		working_base = 12'hAB0;
		src_rdata = 8'h00;
		dst_rdata = 8'h00;
		repeat (2) @(posedge clk);
		#1;
		t_reset();
		nrst = 1'b1;
		t_add();
		t_order();
		t_fields();
		t_pairs();
		t_offsets();
		t_bits();
		conclude();
	end

	initial begin
		#20000;
		n_fail++;
		conclude();
	end

endmodule : opd_decoder_tb
